// File: hdl/cma_core.sv
/*
  Core memory addressing: program counter, return stack, two indirect
  pointers, banked data memory, program memory reads and the ALU and
  reset status register, all reached as an APB slave.
  Assumes an APB master on pclk; one transfer in flight at a time.
*/
`include "cma_defs.svh"
module cma_core (
  input wire logic pclk, // Clock, 200 MHz
  input wire logic presetn, // Async reset, low
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic [`CMA_PM_AW-1:0] pm_fetch_addr, // Wrapped fetch address
  output logic sw_reset // Stack fault reset pulse
);
  cma_pkg::cma_state_e state_q, state_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, swrst_q, swrst_d;
  logic [31:0] prdata_q, prdata_d;
  logic [`CMA_PC_W-1:0] pc_q, pc_d;
  logic ctrl_q, ctrl_d;
  logic [1:0] power_control_register_q, power_control_register_d;
  logic [6:0] faddr_q, faddr_d, pclath_q, pclath_d;
  logic [7:0] w_q, w_d, intcon_q, intcon_d;
  logic [4:0] status_q, status_d, bsr_q, bsr_d;
  logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
  logic [`CMA_PM_AW-1:0] pmaddr_q, pmaddr_d;
  cma_pkg::cma_loc_s loc_q, loc_d;
  cma_pkg::cma_exec_s exec_q, exec_d;
  logic dm_we, pm_we, stk_push, stk_pop, stk_clr;
  logic [7:0] dm_rd, core_rd;
  logic [`CMA_PM_AW-1:0] pm_addr;
  logic [`CMA_PM_DW-1:0] pm_rd;
  logic [`CMA_PC_W-1:0] stk_top;
  logic [4:0] stk_depth;

  ////////////////////////////////////////////////////////////////////////////
  // Place a bank offset in the bank layout
  function automatic cma_pkg::cma_loc_s classify(input logic [4:0] bank,
                                                 input logic [6:0] off);
    cma_pkg::cma_loc_s l;
    l = '0;
    if (off < `CMA_CORE_N) begin
      l.kind = cma_pkg::TG_CORE;
      l.core = off[3:0];
    end else if (off >= `CMA_COM_LO) begin
      l.kind = cma_pkg::TG_RAM;
      l.ram = {5'h00, off};
    end else if (off >= `CMA_GPR_LO) begin
      l.kind = cma_pkg::TG_RAM;
      l.ram = {bank, off};
    end
    return l;
  endfunction

  // Direct or indirect target of a file address
  function automatic cma_pkg::cma_loc_s resolve(input logic [6:0] fa,
                                                input logic [15:0] p0,
                                                input logic [15:0] p1,
                                                input logic [4:0] bank);
    logic [15:0] p;
    cma_pkg::cma_loc_s l;
    p = fa[0] ? p1 : p0;
    l = classify(bank, fa);
    if (fa < `CMA_IND_N) begin
      l = '0;
      if (p[`CMA_PTR_PGM]) begin
        l.kind = cma_pkg::TG_PROG;
        l.prog = p[`CMA_PM_AW-1:0];
      end else if (p[14:12] == 3'h0 && p[6:0] >= `CMA_IND_N) begin
        l = classify(p[11:7], p[6:0]);
      end
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data memory, banked, unused locations simply never addressed
  cma_ram #(
    .AW(`CMA_DM_AW),
    .DW(8)
  ) u_dmem (
    .clk(pclk),
    .we(dm_we),
    .addr(loc_q.ram),
    .wdata(prdata_d[7:0]),
    .rdata_q(dm_rd)
  );

  // Program memory, loaded over the bus only
  cma_ram #(
    .AW(`CMA_PM_AW),
    .DW(`CMA_PM_DW)
  ) u_pmem (
    .clk(pclk),
    .we(pm_we),
    .addr(pm_addr),
    .wdata(pwdata[`CMA_PM_DW-1:0]),
    .rdata_q(pm_rd)
  );

  // Return stack
  cma_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(stk_push),
    .pop(stk_pop),
    .clr(stk_clr),
    .wdata(pc_q),
    .top_q(stk_top),
    .depth_q(stk_depth)
  );

  // Bus loads program memory while idle, pointer reads use the location
  assign pm_addr = (state_q == cma_pkg::ST_IDLE) ? pmaddr_q : loc_q.prog;

  ////////////////////////////////////////////////////////////////////////////
  // Core register read mux, same in every bank
  always_comb begin
    case (loc_q.core)
      `CMA_C_PCL: core_rd = pc_q[7:0];
      `CMA_C_STAT: core_rd = {3'h0, status_q};
      `CMA_C_P0L: core_rd = ptr0_q[7:0];
      `CMA_C_P0H: core_rd = ptr0_q[15:8];
      `CMA_C_P1L: core_rd = ptr1_q[7:0];
      `CMA_C_P1H: core_rd = ptr1_q[15:8];
      `CMA_C_BSR: core_rd = {3'h0, bsr_q};
      `CMA_C_W: core_rd = w_q;
      `CMA_C_PCLATH: core_rd = {1'b0, pclath_q};
      `CMA_C_INTCON: core_rd = intcon_q;
      default: core_rd = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] f;
    logic [7:0] r;
    logic fz;
    logic fc;
    sum = 9'h000;
    nib = 5'h00;
    f = 8'h00;
    r = 8'h00;
    fz = 1'b0;
    fc = 1'b0;
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    swrst_d = 1'b0;
    prdata_d = prdata_q;
    pc_d = pc_q;
    ctrl_d = ctrl_q;
    power_control_register_d = power_control_register_q;
    faddr_d = faddr_q;
    pclath_d = pclath_q;
    w_d = w_q;
    intcon_d = intcon_q;
    status_d = status_q;
    bsr_d = bsr_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    pmaddr_d = pmaddr_q;
    loc_d = loc_q;
    exec_d = exec_q;
    dm_we = 1'b0;
    pm_we = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_clr = 1'b0;
    case (state_q)
      cma_pkg::ST_IDLE: begin
        if (psel && penable) begin
          state_d = cma_pkg::ST_ACK;
          pready_d = 1'b1;
          prdata_d = 32'h0000_0000;
          if (paddr == `CMA_A_CTRL) begin
            if (pwrite) ctrl_d = pwdata[0];
            prdata_d[0] = ctrl_q;
          end else if (paddr == `CMA_A_PC) begin
            if (pwrite) pc_d = pwdata[`CMA_PC_W-1:0];
            prdata_d[`CMA_PC_W-1:0] = pc_q;
          end else if (paddr == `CMA_A_STACK) begin
            prdata_d[4:0] = stk_depth;
            if (pwrite && pwdata[`CMA_STK_PUSH]) begin
              stk_push = 1'b1;
              if (stk_depth == `CMA_STK_DEPTH) power_control_register_d[1] = 1'b1;
            end else if (pwrite && pwdata[`CMA_STK_POP]) begin
              stk_pop = 1'b1;
              pc_d = stk_top;
              if (stk_depth == 5'h00) power_control_register_d[0] = 1'b1;
            end
            // Fault that newly sets a clear flag, with reset enabled, restarts the core
            if (ctrl_q && (power_control_register_d & ~power_control_register_q) != 2'b00) begin
              stk_clr = 1'b1;
              pc_d = '0;
              swrst_d = 1'b1;
            end
          end else if (paddr == `CMA_A_POWER_CONTROL_REGISTER) begin
            // Writing zero clears a flag
            if (pwrite) power_control_register_d = power_control_register_q & pwdata[`CMA_POWER_CONTROL_REGISTER_OVF:`CMA_POWER_CONTROL_REGISTER_UNF];
            prdata_d[`CMA_POWER_CONTROL_REGISTER_OVF:`CMA_POWER_CONTROL_REGISTER_UNF] = power_control_register_q;
          end else if (paddr == `CMA_A_FADDR) begin
            if (pwrite) faddr_d = pwdata[6:0];
            prdata_d[6:0] = faddr_q;
          end else if (paddr == `CMA_A_EXEC) begin
            if (pwrite) begin
              exec_d = pwdata[11:0];
              loc_d = resolve(faddr_q, ptr0_q, ptr1_q, bsr_q);
              state_d = cma_pkg::ST_RD;
              pready_d = 1'b0;
            end
          end else if (paddr == `CMA_A_WREG) begin
            if (pwrite) w_d = pwdata[7:0];
            prdata_d[7:0] = w_q;
          end else if (paddr == `CMA_A_EVENT) begin
            if (pwrite && pwdata[`CMA_EV_WATCHDOG_CLEAR_INSTR]) begin
              status_d[`CMA_ST_TO] = 1'b1;
              status_d[`CMA_ST_PD] = 1'b1;
            end
            if (pwrite && pwdata[`CMA_EV_SLEEP]) begin
              status_d[`CMA_ST_TO] = 1'b1;
              status_d[`CMA_ST_PD] = 1'b0;
            end
            if (pwrite && pwdata[`CMA_EV_TMO]) status_d[`CMA_ST_TO] = 1'b0;
          end else if (paddr == `CMA_A_STATUS) begin
            prdata_d[4:0] = status_q;
          end else if (paddr == `CMA_A_PMADDR) begin
            if (pwrite) pmaddr_d = pwdata[`CMA_PM_AW-1:0];
            prdata_d[`CMA_PM_AW-1:0] = pmaddr_q;
          end else if (paddr == `CMA_A_PMDATA) begin
            pm_we = pwrite;
          end else begin
            pslverr_d = 1'b1;
          end
        end
      end
      cma_pkg::ST_RD: begin
        // Program memory word needs one more cycle
        if (loc_q.kind == cma_pkg::TG_PROG) begin
          state_d = cma_pkg::ST_XTRA;
        end else begin
          state_d = cma_pkg::ST_WB;
        end
      end
      cma_pkg::ST_XTRA: begin
        state_d = cma_pkg::ST_WB;
      end
      cma_pkg::ST_WB: begin
        // Operand fetch; unimplemented reads zero
        case (loc_q.kind)
          cma_pkg::TG_CORE: f = core_rd;
          cma_pkg::TG_RAM: f = dm_rd;
          cma_pkg::TG_PROG: f = pm_rd[7:0];
          default: f = 8'h00;
        endcase
        case (exec_q.op)
          cma_pkg::OP_MOVF: begin
            r = f;
            fz = 1'b1;
          end
          cma_pkg::OP_ADD: begin
            sum = {1'b0, f} + {1'b0, w_q};
            nib = {1'b0, f[3:0]} + {1'b0, w_q[3:0]};
            r = sum[7:0];
            fz = 1'b1;
            fc = 1'b1;
          end
          cma_pkg::OP_SUB: begin
            // Two's complement add, carry high means no borrow
            sum = {1'b0, f} + {1'b0, ~w_q} + 9'h001;
            nib = {1'b0, f[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
            r = sum[7:0];
            fz = 1'b1;
            fc = 1'b1;
          end
          cma_pkg::OP_AND: begin
            r = f & w_q;
            fz = 1'b1;
          end
          cma_pkg::OP_CLR: begin
            r = 8'h00;
            fz = 1'b1;
          end
          cma_pkg::OP_MOVWF: r = w_q;
          cma_pkg::OP_WRLIT: r = exec_q.lit;
          default: r = {f[3:0], f[7:4]};
        endcase
        prdata_d = {24'h00_0000, r};
        if (!exec_q.dest) begin
          w_d = r;
        end else if (loc_q.kind == cma_pkg::TG_RAM) begin
          dm_we = 1'b1;
        end else if (loc_q.kind == cma_pkg::TG_CORE) begin
          case (loc_q.core)
            `CMA_C_PCL: pc_d = {pclath_q, r};
            `CMA_C_STAT: begin
              // Only the low three bits are writable
              if (!(fz || fc)) status_d[2:0] = r[2:0];
            end
            `CMA_C_P0L: ptr0_d[7:0] = r;
            `CMA_C_P0H: ptr0_d[15:8] = r;
            `CMA_C_P1L: ptr1_d[7:0] = r;
            `CMA_C_P1H: ptr1_d[15:8] = r;
            `CMA_C_BSR: bsr_d = r[4:0];
            `CMA_C_W: w_d = r;
            `CMA_C_PCLATH: pclath_d = r[6:0];
            `CMA_C_INTCON: intcon_d = r;
            default: r = r;
          endcase
        end
        // Program memory targets take no write at all
        if (fz) status_d[2] = (r == 8'h00);
        if (fc) begin
          status_d[1] = nib[4];
          status_d[0] = sum[8];
        end
        pready_d = 1'b1;
        state_d = cma_pkg::ST_ACK;
      end
      default: begin
        state_d = cma_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; power-up sets the watchdog and sleep bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cma_pkg::ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      swrst_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pc_q <= '0;
      ctrl_q <= `CMA_CTRL_RST;
      power_control_register_q <= 2'b00;
      faddr_q <= 7'h00;
      pclath_q <= 7'h00;
      w_q <= 8'h00;
      intcon_q <= 8'h00;
      status_q <= `CMA_STATUS_RST;
      bsr_q <= 5'h00;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      pmaddr_q <= '0;
      loc_q <= '0;
      exec_q <= '0;
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      swrst_q <= swrst_d;
      prdata_q <= prdata_d;
      pc_q <= pc_d;
      ctrl_q <= ctrl_d;
      power_control_register_q <= power_control_register_d;
      faddr_q <= faddr_d;
      pclath_q <= pclath_d;
      w_q <= w_d;
      intcon_q <= intcon_d;
      status_q <= status_d;
      bsr_q <= bsr_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      pmaddr_q <= pmaddr_d;
      loc_q <= loc_d;
      exec_q <= exec_d;
    end
  end

  // Outputs straight from registers
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pm_fetch_addr = pc_q[`CMA_PM_AW-1:0];
  assign sw_reset = swrst_q;
endmodule

// File: common/cma_defs.svh
/*
  Offsets, field positions, reset values and sizes of the core memory
  addressing block. Assumes it is included by its bare name.
*/
// Contract
// - Return stack holds sixteen 15-bit entries.
// - Stack over/underflow sets flag, optional reset.
// - Two 16-bit pointers reach data and program.
// - Pointer read of program memory adds one cycle.
// - Program counter is 15 bits wide.
// - 2048-word program memory, higher addresses wrap.
// - Pointer high bit 7 selects program memory.
// - Program read loads low 8 bits only.
// - Pointer writes never alter program memory.
// - Data memory is 32 banks of 128.
// - Bank: core, special, general and common regions.
// - Direct accesses use the bank select value.
// - Unimplemented data locations read as zero.
// - Core registers mirrored in every bank.
// - Flag-setting result blocks status flag writes.
// - Watchdog and sleep status bits are read-only.
// - Status bits 7-5 read zero; layout fixed.
// - Watchdog bit set by power-up, clear, sleep.
// - Sleep bit set by power-up, clear; cleared by sleep.
// - Zero flag follows a zero result.
// - Nibble carry from the fourth bit.
// - Carry from top bit; borrows inverted.
`ifndef CMA_DEFS_SVH
`define CMA_DEFS_SVH
////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CMA_A_CTRL 12'h000
`define CMA_A_PC 12'h004
`define CMA_A_STACK 12'h008
`define CMA_A_POWER_CONTROL_REGISTER 12'h00C
`define CMA_A_FADDR 12'h010
`define CMA_A_EXEC 12'h014
`define CMA_A_WREG 12'h018
`define CMA_A_EVENT 12'h01C
`define CMA_A_STATUS 12'h020
`define CMA_A_PMADDR 12'h024
`define CMA_A_PMDATA 12'h028
////////////////////////////////////////////////////////////////////////////////
// Field positions and reset values
`define CMA_CTRL_RST 1'b1
`define CMA_STATUS_RST 5'h18
`define CMA_ST_TO 4
`define CMA_ST_PD 3
`define CMA_POWER_CONTROL_REGISTER_OVF 7
`define CMA_POWER_CONTROL_REGISTER_UNF 6
`define CMA_EV_WATCHDOG_CLEAR_INSTR 0
`define CMA_EV_SLEEP 1
`define CMA_EV_TMO 2
`define CMA_STK_PUSH 0
`define CMA_STK_POP 1
`define CMA_PTR_PGM 15
////////////////////////////////////////////////////////////////////////////////
// Sizes and bank layout
`define CMA_PC_W 15
`define CMA_PM_AW 11
`define CMA_PM_DW 14
`define CMA_DM_AW 12
`define CMA_STK_DEPTH 5'h10
`define CMA_IND_N 7'h02
`define CMA_CORE_N 7'h0C
`define CMA_GPR_LO 7'h20
`define CMA_COM_LO 7'h70
////////////////////////////////////////////////////////////////////////////////
// Core register slots, same in every bank
`define CMA_C_PCL 4'h2
`define CMA_C_STAT 4'h3
`define CMA_C_P0L 4'h4
`define CMA_C_P0H 4'h5
`define CMA_C_P1L 4'h6
`define CMA_C_P1H 4'h7
`define CMA_C_BSR 4'h8
`define CMA_C_W 4'h9
`define CMA_C_PCLATH 4'hA
`define CMA_C_INTCON 4'hB
`endif

// File: common/cma_pkg.sv
/*
  Types of the core memory addressing block. Assumes cma_defs.svh is on
  the include path.
*/
`include "cma_defs.svh"
package cma_pkg;
  // Transfer sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD = 5'b00010,
    ST_XTRA = 5'b00100,
    ST_WB = 5'b01000,
    ST_ACK = 5'b10000
  } cma_state_e;
  // Where a file access lands
  typedef enum logic [1:0] {TG_NONE, TG_CORE, TG_RAM, TG_PROG} cma_tgt_e;
  // Operations of the execute register
  typedef enum logic [2:0] {
    OP_MOVF, OP_ADD, OP_SUB, OP_AND, OP_CLR, OP_MOVWF, OP_WRLIT, OP_SWAP
  } cma_op_e;
  // Resolved file location
  typedef struct packed {
    cma_tgt_e kind;
    logic [3:0] core;
    logic [`CMA_DM_AW-1:0] ram;
    logic [`CMA_PM_AW-1:0] prog;
  } cma_loc_s;
  // Execute command: destination, operation, literal
  typedef struct packed {
    logic dest;
    cma_op_e op;
    logic [7:0] lit;
  } cma_exec_s;
endpackage

// File: hdl/cma_ram.sv
/*
  Single-port memory with registered read data.
  Assumes one clock; read data follows the address one cycle later.
*/
module cma_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk, // Clock
  input wire logic we, // Write enable
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [DW-1:0] wdata, // Write data
  output logic [DW-1:0] rdata_q // Registered read data
);
  logic [DW-1:0] mem [2**AW];

  // Write and read-before-write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end
endmodule

// File: hdl/cma_stack.sv
/*
  Return address stack. Assumes the caller never asks for push and pop
  in the same cycle; push has priority if it does and the stack is not full.
*/
`include "cma_defs.svh"
module cma_stack (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic push, // Push request
  input wire logic pop, // Pop request
  input wire logic clr, // Empty the stack
  input wire logic [`CMA_PC_W-1:0] wdata, // Address to push
  output logic [`CMA_PC_W-1:0] top_q, // Top entry, zero when empty
  output logic [4:0] depth_q // Entries held
);
  logic [`CMA_PC_W-1:0] mem [16];
  logic [`CMA_PC_W-1:0] top_d;
  logic [4:0] depth_d;
  logic wr;

  ////////////////////////////////////////////////////////////////////////////
  // Next pointer and top; full push and empty pop are dropped
  always_comb begin
    top_d = top_q;
    depth_d = depth_q;
    wr = 1'b0;
    if (clr) begin
      top_d = '0;
      depth_d = 5'h00;
    end else if (push && depth_q != `CMA_STK_DEPTH) begin
      wr = 1'b1;
      top_d = wdata;
      depth_d = depth_q + 5'h01;
    end else if (pop && depth_q != 5'h00) begin
      depth_d = depth_q - 5'h01;
      top_d = (depth_q > 5'h01) ? mem[depth_q[3:0] - 4'h2] : '0;
    end
  end

  // Entry storage
  always_ff @(posedge pclk) begin
    if (wr) begin
      mem[depth_q[3:0]] <= wdata;
    end
  end

  // Pointer and top registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_q <= '0;
      depth_q <= 5'h00;
    end else begin
      top_q <= top_d;
      depth_q <= depth_d;
    end
  end
endmodule

// File: tb/cma_core_chk.sv
/*
  Port checker for cma_core, bound to every instance.
  Assumes one transfer at a time on the APB side, clocked by pclk.
*/
`include "cma_defs.svh"
module cma_core_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [`CMA_PM_AW-1:0] pm_fetch_addr, // Fetch address
  input wire logic sw_reset // Stack fault reset
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ack;
  logic [10:0] pcw_d;
  logic [10:0] pcw_q;
  // Completed transfer and the low bits of the last counter write
  assign ack = psel && penable && pready;
  always_comb begin
    pcw_d = (ack && pwrite && paddr == `CMA_A_PC) ? pwdata[10:0] : pcw_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcw_q <= 11'h000;
    end else begin
      pcw_q <= pcw_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_STK_DEPTH: assert property (ack && !pwrite && paddr == `CMA_A_STACK |->
    prdata <= 32'h0000_0010) else $error("stack depth above sixteen");
  AST_POWER_CONTROL_REGISTER_BITS: assert property (ack && !pwrite && paddr == `CMA_A_POWER_CONTROL_REGISTER |->
    (prdata & 32'hFFFF_FF3F) == 32'h0000_0000) else $error("stray power control bits");
  AST_SWRST_ONE: assert property (sw_reset |=> !sw_reset)
    else $error("fault reset longer than one cycle");
  AST_SWRST_CAUSE: assert property ($rose(sw_reset) |->
    $past(psel && pwrite && paddr == `CMA_A_STACK) ||
    $past(psel && pwrite && paddr == `CMA_A_STACK, 2)) else $error("fault reset uncaused");
  AST_EXEC_WAIT: assert property (
    $rose(psel && penable) && pwrite && paddr == `CMA_A_EXEC |-> !pready [*3] ##[1:2] pready)
    else $error("execute wait count wrong");
  AST_PC_WIDTH: assert property (ack && !pwrite && paddr == `CMA_A_PC |->
    prdata[31:15] == 17'h0_0000) else $error("counter wider than 15 bits");
  AST_FETCH_WRAP: assert property (ack && pwrite && paddr == `CMA_A_PC |->
    ##[1:2] pm_fetch_addr == pcw_q) else $error("fetch address not wrapped");
  AST_EXEC_BYTE: assert property (ack && paddr == `CMA_A_EXEC |->
    prdata[31:8] == 24'h00_0000) else $error("result wider than a byte");
  AST_STATUS_TOP: assert property (ack && !pwrite && paddr == `CMA_A_STATUS |->
    prdata[31:5] == 27'h000_0000) else $error("status top bits set");
endmodule
bind cma_core cma_core_chk u_cma_core_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .pm_fetch_addr, .sw_reset);

// File: tb/cma_core_tb.sv
/*
  Self-checking bench for cma_core over APB.
  Assumes the checker is bound separately; 200 MHz clock.
*/
`include "cma_defs.svh"
module cma_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, got, r, seed = 32'h0000_56D5;
  logic pready, pslverr, sw_reset, err, swr_seen = 1'b0;
  logic [10:0] pm_fetch_addr, e;
  logic [2:0] op;
  logic [7:0] bk_tab [3] = '{8'h00, 8'h05, 8'h1F};
  int bad_count = 0, num_checks = 0, cyc = 0, nwait;
  always #2.5 pclk = ~pclk;
  cma_core u_cma_core (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .pm_fetch_addr, .sw_reset);
  // Hang guard and fault reset pulse catcher
  always @(posedge pclk) begin
    cyc++;
    if (sw_reset === 1'b1) swr_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sum or difference of file and W, then zero, nibble carry and carry
  function automatic logic [10:0] alu(input logic [2:0] o, input logic [7:0] f,
                                      input logic [7:0] w);
    logic [8:0] s;
    logic [4:0] n;
    s = (o == 3'd1) ? {1'b0, f} + {1'b0, w} : {1'b0, f} + {1'b0, ~w} + 9'h001;
    n = (o == 3'd1) ? {1'b0, f[3:0]} + {1'b0, w[3:0]} : {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
    return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer; psel stays up so the next setup may follow at once
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    nwait = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      nwait++;
      @(posedge pclk);
    end
    got = prdata;
    err = pslverr;
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(got, x);
  endtask
  task automatic ex(input logic [6:0] f, input logic [2:0] o, input logic dst,
                    input logic [7:0] lit);
    wr(`CMA_A_FADDR, {25'h0, f});
    wr(`CMA_A_EXEC, {20'h0, dst, o, lit});
  endtask
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only and event-driven status bits
    rdc(`CMA_A_STATUS, 32'h0000_0018);
    rdc(`CMA_A_CTRL, 32'h0000_0001);
    wr(`CMA_A_STATUS, 32'h0000_00FF);
    rdc(`CMA_A_STATUS, 32'h0000_0018);
    wr(`CMA_A_EVENT, 32'h0000_0002);
    rdc(`CMA_A_STATUS, 32'h0000_0010);
    ex(7'h03, 3'd6, 1'b1, 8'hFF);
    rdc(`CMA_A_STATUS, 32'h0000_0017);
    wr(`CMA_A_EVENT, 32'h0000_0004);
    rdc(`CMA_A_STATUS, 32'h0000_0007);
    wr(`CMA_A_EVENT, 32'h0000_0001);
    rdc(`CMA_A_STATUS, 32'h0000_001F);
    ex(7'h03, 3'd6, 1'b1, 8'h00);
    ex(7'h03, 3'd4, 1'b1, 8'h00);
    rdc(`CMA_A_STATUS, 32'h0000_001C);
    // Random sums and differences with corner pairs first
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      if (i == 0) r = 32'h0000_0000;
      if (i == 1) r = 32'h0000_FF01;
      if (i == 2) r = 32'h0001_1001;
      op = 3'd1 + {2'b00, r[16]};
      e = alu(op, r[15:8], r[7:0]);
      wr(`CMA_A_WREG, {24'h0, r[7:0]});
      ex(7'h20, 3'd6, 1'b1, r[15:8]);
      ex(7'h20, op, 1'b0, 8'h00);
      chk(got, {24'h0, e[10:3]});
      rdc(`CMA_A_STATUS, {27'h0, 2'b11, e[2:0]});
    end
    // Banked RAM, core mirror, common RAM, empty region
    wr(`CMA_A_WREG, 32'h0000_005C);
    for (int b = 0; b < 3; b++) begin
      ex(7'h08, 3'd6, 1'b1, bk_tab[b]);
      ex(7'h20, 3'd6, 1'b1, 8'hA0 ^ bk_tab[b]);
      ex(7'h7F, 3'd6, 1'b1, 8'h30 + bk_tab[b]);
    end
    for (int b = 0; b < 3; b++) begin
      ex(7'h08, 3'd6, 1'b1, bk_tab[b]);
      ex(7'h20, 3'd0, 1'b0, 8'h00);
      chk(got, {24'h0, 8'hA0 ^ bk_tab[b]});
      ex(7'h7F, 3'd0, 1'b0, 8'h00);
      chk(got, 32'h0000_004F);
      wr(`CMA_A_WREG, 32'h0000_005C);
      ex(7'h09, 3'd0, 1'b0, 8'h00);
      chk(got, 32'h0000_005C);
      ex(7'h0C, 3'd0, 1'b0, 8'h00);
      chk(got, 32'h0000_0000);
    end
    // Swap, and, then W into status: only the low three bits land
    ex(7'h7F, 3'd7, 1'b0, 8'h00);
    chk(got, 32'h0000_00F4);
    ex(7'h7F, 3'd3, 1'b0, 8'h00);
    chk(got, 32'h0000_0044);
    ex(7'h03, 3'd5, 1'b1, 8'h00);
    rdc(`CMA_A_STATUS, 32'h0000_001C);
    // Pointer into program memory beyond the top, then into data memory
    wr(`CMA_A_PMADDR, 32'h0000_07FF);
    wr(`CMA_A_PMDATA, 32'h0000_3ABC);
    ex(7'h04, 3'd6, 1'b1, 8'hFF);
    ex(7'h05, 3'd6, 1'b1, 8'h8F);
    ex(7'h00, 3'd0, 1'b0, 8'h00);
    chk(got, 32'h0000_00BC);
    chk(32'(nwait), 32'h0000_0004);
    ex(7'h00, 3'd6, 1'b1, 8'h11);
    ex(7'h00, 3'd0, 1'b0, 8'h00);
    chk(got, 32'h0000_00BC);
    ex(7'h08, 3'd6, 1'b1, 8'h02);
    ex(7'h20, 3'd6, 1'b1, 8'h77);
    ex(7'h06, 3'd6, 1'b1, 8'h20);
    ex(7'h07, 3'd6, 1'b1, 8'h01);
    ex(7'h01, 3'd0, 1'b0, 8'h00);
    chk(got, 32'h0000_0077);
    chk(32'(nwait), 32'h0000_0003);
    // Program counter width and fetch wrap
    wr(`CMA_A_PC, 32'h0000_7FFF);
    rdc(`CMA_A_PC, 32'h0000_7FFF);
    wr(`CMA_A_PC, 32'h0000_0C05);
    idle(3);
    chk({21'h0, pm_fetch_addr}, 32'h0000_0405);
    // Stack faults without and with the fault reset
    wr(`CMA_A_CTRL, 32'h0000_0000);
    wr(`CMA_A_STACK, 32'h0000_0002);
    rdc(`CMA_A_POWER_CONTROL_REGISTER, 32'h0000_0040);
    for (int i = 0; i < 17; i++) wr(`CMA_A_STACK, 32'h0000_0001);
    rdc(`CMA_A_STACK, 32'h0000_0010);
    rdc(`CMA_A_POWER_CONTROL_REGISTER, 32'h0000_00C0);
    wr(`CMA_A_POWER_CONTROL_REGISTER, 32'h0000_0000);
    for (int i = 0; i < 16; i++) wr(`CMA_A_STACK, 32'h0000_0002);
    rdc(`CMA_A_STACK, 32'h0000_0000);
    chk({31'h0, swr_seen}, 32'h0000_0000);
    wr(`CMA_A_CTRL, 32'h0000_0001);
    wr(`CMA_A_STACK, 32'h0000_0002);
    idle(3);
    chk({31'h0, swr_seen}, 32'h0000_0001);
    rdc(`CMA_A_POWER_CONTROL_REGISTER, 32'h0000_0040);
    // Unmapped and unaligned addresses
    xfer(12'h030, 1'b0, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(12'h002, 1'b1, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0001);
    idle(2);
    end_sim();
  end
endmodule
